// ===== shared/ctc_defines.svh
// constants of the control timer counter core
`ifndef CTC_DEFINES_SVH
`define CTC_DEFINES_SVH

`define CTC_COUNT_W      16
`define CTC_CHAN_N       4
`define CTC_ACT_W        3
`define CTC_CMD_W        3

// event action codes
`define CTC_ACT_OFF      3'h0
`define CTC_ACT_RETRIG   3'h1
`define CTC_ACT_DIR      3'h2
`define CTC_ACT_STOP     3'h3
`define CTC_ACT_START    3'h3
`define CTC_ACT_INC      3'h4
`define CTC_ACT_DEC      3'h4
`define CTC_ACT_COUNT    3'h5
`define CTC_ACT_FAULT    3'h7

// command codes
`define CTC_CMD_NONE     3'h0
`define CTC_CMD_RETRIG   3'h1
`define CTC_CMD_STOP     3'h2
`define CTC_CMD_UPDATE   3'h3

// reset values and count constants
`define CTC_COUNT_RST    16'h0000
`define CTC_CC_RST       16'h0000
`define CTC_ZERO         16'h0000
`define CTC_ONE          16'h0001

`endif

// ===== shared/ctc_pkg.sv
// types shared by the control timer counter core
package ctc_pkg;

    typedef enum logic [2:0] {
        normal_frequency_mode,
        match_frequency_mode,
        single_slope_pwm_mode,
        dual_slope_critical_mode,
        dual_slope_zero_mode,
        dual_slope_both_ends_mode,
        dual_slope_top_mode
    } ctc_wave_mode_t;

    typedef enum {
        ctc_stopped,
        ctc_counting
    } ctc_run_t;

endpackage

// ===== core/ctc_event_sync.sv
// three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps
module ctc_event_sync (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // pin side
    input  wire logic pin_in,
    // core side
    output logic      level,
    output logic      rise
);
    logic stage1, stage2, stage3;
    logic next_level, next_rise;

    always_comb begin
        // a change counts once stage2 and stage3 agree
        next_level = level;
        if (stage2 == stage3) begin
            next_level = stage3;
        end
        next_rise = next_level & ~level;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            level  <= 1'b0;
            rise   <= 1'b0;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            level  <= next_level;
            rise   <= next_rise;
        end
    end
endmodule

// ===== core/ctc_compare_channel.sv
// one compare channel: buffer, match and waveform
`timescale 1ns/1ps
`include "ctc_defines.svh"
module ctc_compare_channel import ctc_pkg::*; (
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    reset,
    // counter state
    input  wire logic [`CTC_COUNT_W-1:0] count_value,
    input  wire logic [`CTC_COUNT_W-1:0] top_value,
    input  wire logic                    count_fire,
    input  wire logic                    going_down,
    input  wire ctc_wave_mode_t          waveform_mode_select,
    // buffer control
    input  wire logic                    buffer_write,
    input  wire logic [`CTC_COUNT_W-1:0] buffer_data,
    input  wire logic                    update_point,
    input  wire logic                    lock_buffer_update,
    input  wire logic                    force_update,
    // output drive
    input  wire logic                    fault_active,
    input  wire logic                    fault_override_enable,
    input  wire logic                    fault_override_value,
    input  wire logic                    output_invert_enable,
    // results
    output logic [`CTC_COUNT_W-1:0]      compare_value,
    output logic                         match,
    output logic                         channel_wave_output
);
    logic [`CTC_COUNT_W-1:0] compare_value_buffer, next_buffer, next_cc;
    logic                    buffer_valid, next_valid;
    logic                    wave, next_wave, next_out;

    always_comb begin
        next_buffer = compare_value_buffer;
        next_valid  = buffer_valid;
        next_cc     = compare_value;
        if ((update_point && !lock_buffer_update && buffer_valid)
                || force_update) begin // [RULE_16]
            next_cc    = compare_value_buffer;
            next_valid = 1'b0;
        end
        // a write in the same cycle waits for the next update
        if (buffer_write) begin
            next_buffer = buffer_data;
            next_valid  = 1'b1;
        end
        match = count_fire && (count_value == compare_value); // [RULE_17]
        next_wave = wave;
        unique case (waveform_mode_select)
            normal_frequency_mode, match_frequency_mode: begin
                if (match) begin
                    next_wave = ~wave; // [RULE_20]
                end
            end
            single_slope_pwm_mode: begin
                if (!going_down) begin
                    if (count_fire && count_value == top_value) begin
                        next_wave = 1'b1;
                    end else if (match) begin
                        next_wave = 1'b0;
                    end
                end else begin
                    if (count_fire && count_value == `CTC_ZERO) begin
                        next_wave = 1'b0;
                    end else if (match) begin
                        next_wave = 1'b1;
                    end
                end
            end
            default: begin
                // dual slope: set on the rising ramp, clear on the falling
                if (match) begin
                    next_wave = !going_down;
                end
            end
        endcase
        if (fault_active && fault_override_enable) begin
            next_out = fault_override_value; // [RULE_14]
        end else begin
            next_out = next_wave ^ output_invert_enable;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            compare_value_buffer <= `CTC_CC_RST;
            buffer_valid         <= 1'b0;
            compare_value        <= `CTC_CC_RST;
            wave                 <= 1'b0;
            channel_wave_output  <= 1'b0;
        end else begin
            compare_value_buffer <= next_buffer;
            buffer_valid         <= next_valid;
            compare_value        <= next_cc;
            wave                 <= next_wave;
            channel_wave_output  <= next_out;
        end
    end
endmodule

// ===== core/ctc_core.sv
// counter core of the control timer
//
// What this block does
// [RULE_01] software count write wins, anytime
// [RULE_02] start at ZERO up, TOP down
// [RULE_03] stop command code 2 stops counter
// [RULE_04] input1 action 3 pauses counter
// [RULE_05] retrigger clears or reloads, sets flag
// [RULE_06] retrigger emits event when enabled
// [RULE_07] retrigger while stopped resumes from count
// [RULE_08] retrigger action: enable waits for event
// [RULE_09] input0 start action starts once only
// [RULE_10] input0 count action: events step counter
// [RULE_11] input1 direction action: level sets direction
// [RULE_12] input0 increment action counts up
// [RULE_13] input1 decrement action counts down
// [RULE_14] fault action stops, forces channel outputs
// [RULE_15] all actions off: enable starts counting
// [RULE_16] buffer copies at update or force
// [RULE_17] match sets flag, optional event
// [RULE_18] seven modes; TOP from channel 0 or period
// [RULE_19] update at ZERO dual, else wrap
// [RULE_20] normal frequency: toggle on match
// [RULE_21] wrap flag and event per mode
// [RULE_22] software keeps events off waveform channels
// [RULE_23] direction zero up, one down
// [RULE_24] up wraps to zero, down reloads TOP
// [RULE_25] stopped counter holds, ignores ticks
`timescale 1ns/1ps
`include "ctc_defines.svh"
module ctc_core import ctc_pkg::*; (
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    reset,
    // control
    input  wire logic                    enable,
    input  wire logic                    cmd_valid,
    input  wire logic [`CTC_CMD_W-1:0]   cmd_code,
    input  wire logic                    dir_set,
    input  wire logic                    dir_clear,
    input  wire logic                    count_write,
    input  wire logic [`CTC_COUNT_W-1:0] count_write_data,
    input  wire logic                    prescale_tick,
    // configuration
    input  wire ctc_wave_mode_t          waveform_mode_select,
    input  wire logic [`CTC_ACT_W-1:0]   input0_event_action,
    input  wire logic [`CTC_ACT_W-1:0]   input1_event_action,
    input  wire logic [`CTC_COUNT_W-1:0] cycle_length_value,
    input  wire logic                    lock_buffer_update,
    input  wire logic                    circular_buffer_enable,
    input  wire logic                    retrigger_event_out_enable,
    input  wire logic                    wrap_event_out_enable,
    input  wire logic [`CTC_CHAN_N-1:0]  channel_match_event_enable,
    input  wire logic [`CTC_CHAN_N-1:0]  fault_override_enable,
    input  wire logic [`CTC_CHAN_N-1:0]  fault_override_value,
    input  wire logic [`CTC_CHAN_N-1:0]  output_invert_enable,
    // compare buffer writes
    input  wire logic [`CTC_CHAN_N-1:0]  buffer_write,
    input  wire logic [`CTC_COUNT_W-1:0] buffer_data,
    // flag clears
    input  wire logic                    wrap_flag_clear,
    input  wire logic                    retrigger_flag_clear,
    input  wire logic [`CTC_CHAN_N-1:0]  channel_match_flag_clear,
    input  wire logic                    fault_clear,
    // event inputs
    input  wire logic                    event_input_zero,
    input  wire logic                    event_input_one,
    // status
    output logic [`CTC_COUNT_W-1:0]      count_value,
    output logic                         direction,
    output logic                         running,
    output logic                         fault_active,
    output logic                         wrap_flag,
    output logic                         retrigger_flag,
    output logic [`CTC_CHAN_N-1:0]       channel_match_flag,
    // event and waveform outputs
    output logic                         wrap_event_out,
    output logic                         retrigger_event_out,
    output logic [`CTC_CHAN_N-1:0]       channel_match_event_out,
    output logic [`CTC_CHAN_N-1:0]       channel_wave_output
);
    logic                    ev0_level, ev0_rise, ev1_level, ev1_rise;
    ctc_run_t                run_state, next_run_state;
    logic [`CTC_COUNT_W-1:0] next_count, top_value;
    logic                    slope_down, next_slope_down;
    logic                    next_direction, going_down;
    logic                    enable_seen, next_fault;
    logic                    next_wrap_flag, next_retrigger_flag;
    logic [`CTC_CHAN_N-1:0]  next_match_flag, match;
    logic                    do_retrigger, do_stop, do_start, count_fire;
    logic                    hit_top, hit_zero, wrap_point, update_point;
    logic                    force_update, step_inc, step_dec, dual_slope;
    logic                    waits_for_event;
    logic [`CTC_COUNT_W-1:0] compare_value [`CTC_CHAN_N];

    function automatic logic [`CTC_COUNT_W-1:0] step_by_one(
        input logic [`CTC_COUNT_W-1:0] value,
        input logic                    down
    );
        if (down) begin
            step_by_one = value - `CTC_ONE;
        end else begin
            step_by_one = value + `CTC_ONE;
        end
    endfunction

    ctc_event_sync u_sync_zero (
        .core_clk (core_clk),
        .reset    (reset),
        .pin_in   (event_input_zero),
        .level    (ev0_level),
        .rise     (ev0_rise)
    );

    ctc_event_sync u_sync_one (
        .core_clk (core_clk),
        .reset    (reset),
        .pin_in   (event_input_one),
        .level    (ev1_level),
        .rise     (ev1_rise)
    );

    genvar ch;
    generate
        for (ch = 0; ch < `CTC_CHAN_N; ch++) begin : g_chan
            ctc_compare_channel u_chan (
                .core_clk              (core_clk),
                .reset                 (reset),
                .count_value           (count_value),
                .top_value             (top_value),
                .count_fire            (count_fire),
                .going_down            (going_down),
                .waveform_mode_select  (waveform_mode_select),
                .buffer_write          (buffer_write[ch]),
                .buffer_data           (buffer_data),
                .update_point          (update_point),
                .lock_buffer_update    (lock_buffer_update),
                .force_update          (force_update),
                .fault_active          (fault_active),
                .fault_override_enable (fault_override_enable[ch]),
                .fault_override_value  (fault_override_value[ch]),
                .output_invert_enable  (output_invert_enable[ch]),
                .compare_value         (compare_value[ch]),
                .match                 (match[ch]),
                .channel_wave_output   (channel_wave_output[ch])
            );
        end
    endgenerate

    always_comb begin
        dual_slope = waveform_mode_select inside {dual_slope_critical_mode,
            dual_slope_zero_mode, dual_slope_both_ends_mode,
            dual_slope_top_mode};
        if (waveform_mode_select == match_frequency_mode) begin
            top_value = compare_value[0]; // [RULE_18]
        end else begin
            top_value = cycle_length_value; // [RULE_18]
        end
        going_down = dual_slope ? slope_down : direction; // [RULE_23]

        force_update = cmd_valid && cmd_code == `CTC_CMD_UPDATE;
        do_retrigger = enable && ((cmd_valid && cmd_code == `CTC_CMD_RETRIG)
            || (ev0_rise && input0_event_action == `CTC_ACT_RETRIG)
            || (ev1_rise && input1_event_action == `CTC_ACT_RETRIG)); // [RULE_05]
        do_stop = (cmd_valid && cmd_code == `CTC_CMD_STOP) // [RULE_03]
            || (ev1_rise && input1_event_action == `CTC_ACT_STOP); // [RULE_04]
        next_fault = fault_active && !fault_clear;
        if ((ev0_rise && input0_event_action == `CTC_ACT_FAULT)
                || (ev1_rise && input1_event_action == `CTC_ACT_FAULT)) begin
            next_fault = 1'b1; // [RULE_14]
            do_stop    = 1'b1; // [RULE_14]
        end
        do_start = enable && run_state == ctc_stopped && ev0_rise
            && input0_event_action == `CTC_ACT_START; // [RULE_09]
        waits_for_event = input0_event_action == `CTC_ACT_RETRIG
            || input1_event_action == `CTC_ACT_RETRIG
            || input0_event_action == `CTC_ACT_START; // [RULE_08] [RULE_09]

        if (input0_event_action == `CTC_ACT_COUNT) begin
            count_fire = ev0_rise; // [RULE_10]
        end else begin
            count_fire = prescale_tick;
        end
        step_inc = ev0_rise && input0_event_action == `CTC_ACT_INC;
        step_dec = ev1_rise && input1_event_action == `CTC_ACT_DEC;
        count_fire = count_fire && run_state == ctc_counting; // [RULE_25]

        next_direction = direction;
        if (dir_set) begin
            next_direction = 1'b1;
        end else if (dir_clear) begin
            next_direction = 1'b0;
        end
        if (input1_event_action == `CTC_ACT_DIR) begin
            next_direction = ev1_level; // [RULE_11]
        end

        hit_top  = count_fire && !going_down && count_value >= top_value;
        hit_zero = count_fire && going_down && count_value == `CTC_ZERO;
        next_count      = count_value;
        next_slope_down = slope_down;
        next_run_state  = run_state;
        wrap_point      = 1'b0;
        update_point    = 1'b0;

        if (count_fire) begin
            if (dual_slope) begin
                if (hit_top) begin
                    next_slope_down = 1'b1;
                    next_count      = step_by_one(count_value, 1'b1);
                    wrap_point = waveform_mode_select
                        inside {dual_slope_both_ends_mode,
                                dual_slope_top_mode}; // [RULE_21]
                    update_point = circular_buffer_enable && waveform_mode_select
                        == dual_slope_both_ends_mode; // [RULE_21]
                end else if (hit_zero) begin
                    next_slope_down = 1'b0;
                    next_count      = step_by_one(count_value, 1'b0);
                    wrap_point = waveform_mode_select
                        != dual_slope_top_mode; // [RULE_21]
                    update_point = 1'b1; // [RULE_19]
                end else begin
                    next_count = step_by_one(count_value, slope_down);
                end
            end else if (hit_top) begin
                next_count   = `CTC_ZERO; // [RULE_24]
                wrap_point   = 1'b1; // [RULE_24]
                update_point = 1'b1; // [RULE_19]
            end else if (hit_zero) begin
                next_count   = top_value; // [RULE_24]
                wrap_point   = 1'b1; // [RULE_24]
                update_point = 1'b1; // [RULE_19]
            end else begin
                next_count = step_by_one(count_value, direction);
            end
        end else if (run_state == ctc_counting && (step_inc || step_dec)) begin
            // opposite requests in one cycle cancel out
            if (step_inc && !step_dec) begin
                next_count = step_by_one(count_value, 1'b0); // [RULE_12]
            end else if (step_dec && !step_inc) begin
                next_count = step_by_one(count_value, 1'b1); // [RULE_13]
            end
        end

        if (do_retrigger) begin
            if (run_state == ctc_counting) begin
                // retrigger restarts the cycle from its starting end
                next_count      = direction ? top_value : `CTC_ZERO; // [RULE_05]
                next_slope_down = 1'b0;
                update_point    = !dual_slope; // [RULE_19]
            end
            next_run_state = ctc_counting; // [RULE_07]
        end
        if (do_start) begin
            next_run_state = ctc_counting; // [RULE_09]
        end
        if (enable && !enable_seen) begin
            if (!waits_for_event) begin
                next_run_state = ctc_counting; // [RULE_15]
            end
            if (direction && count_value == `CTC_ZERO) begin
                next_count = top_value; // [RULE_02]
            end
        end
        if (do_stop || !enable) begin
            next_run_state = ctc_stopped; // [RULE_25]
        end
        if (count_write) begin
            next_count = count_write_data; // [RULE_01]
        end

        // a set in the same cycle as a clear wins
        next_wrap_flag = (wrap_flag && !wrap_flag_clear) || wrap_point;
        next_retrigger_flag = (retrigger_flag && !retrigger_flag_clear)
            || (do_retrigger && run_state == ctc_counting); // [RULE_05]
        next_match_flag = (channel_match_flag & ~channel_match_flag_clear)
            | match; // [RULE_17]
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            run_state               <= ctc_stopped;
            count_value             <= `CTC_COUNT_RST;
            slope_down              <= 1'b0;
            direction               <= 1'b0;
            enable_seen             <= 1'b0;
            running                 <= 1'b0;
            fault_active            <= 1'b0;
            wrap_flag               <= 1'b0;
            retrigger_flag          <= 1'b0;
            channel_match_flag      <= '0;
            wrap_event_out          <= 1'b0;
            retrigger_event_out     <= 1'b0;
            channel_match_event_out <= '0;
        end else begin
            run_state               <= next_run_state;
            count_value             <= next_count;
            slope_down              <= next_slope_down;
            direction               <= next_direction;
            enable_seen             <= enable;
            running                 <= next_run_state == ctc_counting;
            fault_active            <= next_fault;
            wrap_flag               <= next_wrap_flag;
            retrigger_flag          <= next_retrigger_flag;
            channel_match_flag      <= next_match_flag;
            wrap_event_out          <= wrap_point && wrap_event_out_enable;
            retrigger_event_out     <= do_retrigger
                && retrigger_event_out_enable; // [RULE_06]
            channel_match_event_out <= match
                & channel_match_event_enable; // [RULE_17]
        end
    end
endmodule

// ===== tb/ctc_core_checker.sv
// port assertions for the control timer counter core
`timescale 1ns/1ps
`include "ctc_defines.svh"
module ctc_core_checker import ctc_pkg::*; (
    // clock, reset and control
    input wire logic core_clk, reset, enable, cmd_valid, dir_set, count_write,
    input wire logic prescale_tick, retrigger_event_out_enable,
    input wire logic [`CTC_CMD_W-1:0]   cmd_code,
    input wire logic [`CTC_COUNT_W-1:0] count_write_data, cycle_length_value,
    input wire ctc_wave_mode_t          waveform_mode_select,
    input wire logic [`CTC_ACT_W-1:0]   input0_event_action, input1_event_action,
    // pins and status
    input wire logic event_input_zero, direction, running, fault_active,
    input wire logic wrap_flag, retrigger_event_out,
    input wire logic [`CTC_COUNT_W-1:0] count_value
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    wire logic up_nf = !direction && !count_write &&
        waveform_mode_select == normal_frequency_mode;
    wire logic acts_off = input0_event_action == `CTC_ACT_OFF &&
        input1_event_action == `CTC_ACT_OFF;
    wire logic rt = cmd_valid && cmd_code == `CTC_CMD_RETRIG && running &&
        enable && up_nf;
    chk_write_wins: assert property (count_write |=>
        count_value == $past(count_write_data)) else $error("write lost");
    chk_stop_cmd: assert property (cmd_valid && !count_write &&
        cmd_code == `CTC_CMD_STOP |=> !running) else $error("stop ignored");
    chk_retrig_clear: assert property (rt |=>
        count_value == 16'h0000) else $error("no clear");
    chk_retrig_event: assert property (rt && retrigger_event_out_enable
        |=> retrigger_event_out) else $error("no event");
    chk_stopped_hold: assert property (!running && !enable &&
        !count_write |=> $stable(count_value)) else $error("stopped moved");
    chk_enable_start: assert property ($rose(enable) && acts_off &&
        !cmd_valid |=> running) else $error("no start");
    chk_wrap_up: assert property (running && enable && prescale_tick &&
        up_nf && acts_off && !cmd_valid && count_value == cycle_length_value
        |=> count_value == 16'h0000 ##[0:1] wrap_flag) else $error("no wrap");
    chk_dir_set: assert property (dir_set &&
        input1_event_action != `CTC_ACT_DIR |=> direction) else $error("dir");
    chk_fault_stop: assert property ($rose(event_input_zero) &&
        input0_event_action == `CTC_ACT_FAULT |-> ##[3:7]
        (fault_active && !running)) else $error("no halt");
endmodule
bind ctc_core ctc_core_checker u_ctc_core_checker (.*);

// ===== tb/ctc_event_model.sv
// event system stand-in driving the event pins
`timescale 1ns/1ps
module ctc_event_model (
    // clock and requests
    input  wire logic       core_clk,
    input  wire logic [1:0] fire,
    // event pins
    output logic            ev0,
    output logic            ev1
);
    logic [3:0] hold0 = 4'h0;
    logic [3:0] hold1 = 4'h0;
    // four clocks high so the filter never drops an event
    always @(posedge core_clk) begin
        hold0 <= {hold0[2:0], fire[0]};
        hold1 <= {hold1[2:0], fire[1]};
    end
    assign ev0 = |hold0;
    assign ev1 = |hold1;
endmodule

// ===== tb/control_timer_counter_core_test.sv
// bench for the control timer counter core
`timescale 1ns/1ps
`include "ctc_defines.svh"
module control_timer_counter_core_test import ctc_pkg::*;;
    logic core_clk = 0, reset = 1, enable = 0, cmd_valid = 0, dir_set = 0;
    logic dir_clear = 0, count_write = 0, prescale_tick = 0, fault_clear = 0;
    logic lock_buffer_update = 0, circular_buffer_enable = 0;
    logic retrigger_event_out_enable = 1, wrap_event_out_enable = 1;
    logic wrap_flag_clear = 0, retrigger_flag_clear = 0;
    logic [2:0] cmd_code = 0, input0_event_action = 0, input1_event_action = 0;
    logic [15:0] count_write_data = 0, cycle_length_value = 16'h0005;
    logic [15:0] buffer_data = 16'h0003, count_value;
    logic [3:0] channel_match_event_enable = 4'hf, fault_override_enable = 4'hf;
    logic [3:0] fault_override_value = 4'ha, output_invert_enable = 4'h0;
    logic [3:0] buffer_write = 0, channel_match_flag_clear = 0;
    logic [3:0] channel_match_flag, channel_match_event_out, channel_wave_output;
    logic direction, running, fault_active, wrap_flag, retrigger_flag;
    logic wrap_event_out, retrigger_event_out, event_input_zero, event_input_one;
    logic [1:0] fire = 0;
    ctc_wave_mode_t waveform_mode_select = normal_frequency_mode;
    int err_total = 0, checks_done = 0;
    ctc_core u_ctc_core (.*);
    ctc_event_model u_ctc_event_model (.core_clk, .fire,
        .ev0(event_input_zero), .ev1(event_input_one));
    always #50 core_clk = ~core_clk;
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task chk(input logic [15:0] seen, input logic [15:0] want);
        checks_done++;
        if (seen !== want) begin
            err_total++;
            $display("Error t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic pulse(ref logic s, input int n);
        s = 1'h1;
        cyc(n);
        s = 1'h0;
    endtask
    task cmd(input logic [2:0] c);
        cmd_code = c;
        pulse(cmd_valid, 1);
    endtask
    // the pin path needs about five clocks
    task evt(input int i);
        fire[i] = 1'h1;
        cyc(1);
        fire[i] = 1'h0;
        cyc(8);
    endtask
    task wrap_up;
        $display("checks=%0d mismatches=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task t_run;
        enable = 1'h1;
        cyc(1);
        chk(running, 1'h1);
        pulse(prescale_tick, 6);
        chk(count_value, 16'h0000);
        chk(wrap_event_out, 1'h1);
        cyc(1);
        chk(wrap_flag, 1'h1);
        count_write_data = 16'h0003;
        prescale_tick = 1'h1;
        pulse(count_write, 1);
        prescale_tick = 1'h0;
        chk(count_value, 16'h0003);
        cmd(`CTC_CMD_RETRIG);
        chk(count_value, 16'h0000);
        chk(retrigger_event_out, 1'h1);
        chk(retrigger_flag, 1'h1);
        pulse(prescale_tick, 2);
        cmd(`CTC_CMD_STOP);
        chk(running, 1'h0);
        pulse(prescale_tick, 3);
        cmd(`CTC_CMD_RETRIG);
        chk(count_value, 16'h0002);
        pulse(dir_set, 1);
        pulse(prescale_tick, 3);
        chk(count_value, 16'h0005);
        $display("run test done");
    endtask
    task t_events;
        input0_event_action = `CTC_ACT_COUNT;
        evt(0);
        pulse(prescale_tick, 2);
        chk(count_value, 16'h0004);
        input0_event_action = `CTC_ACT_INC;
        evt(0);
        chk(count_value, 16'h0005);
        input0_event_action = `CTC_ACT_OFF;
        input1_event_action = `CTC_ACT_STOP;
        evt(1);
        chk(running, 1'h0);
        input1_event_action = `CTC_ACT_OFF;
        input0_event_action = `CTC_ACT_FAULT;
        evt(0);
        chk(channel_wave_output, fault_override_value);
        input0_event_action = `CTC_ACT_OFF;
        pulse(fault_clear, 1);
        $display("event test done");
    endtask
    task t_compare;
        enable = 1'h0;
        pulse(dir_clear, 1);
        count_write_data = 16'h0000;
        buffer_write = 4'h1;
        channel_match_flag_clear = 4'h1;
        pulse(count_write, 1);
        buffer_write = 4'h0;
        channel_match_flag_clear = 4'h0;
        cmd(`CTC_CMD_UPDATE);
        enable = 1'h1;
        cyc(1);
        pulse(prescale_tick, 3);
        chk(channel_match_flag[0], 1'h0);
        cyc(1);
        pulse(prescale_tick, 1);
        chk(channel_match_flag[0], 1'h1);
        chk(channel_match_event_out[0], 1'h1);
        $display("compare test done");
    endtask
    initial begin
        cyc(12);
        reset = 1'h0;
        t_run;
        t_events;
        t_compare;
        wrap_up;
    end
    initial begin
        cyc(1000);
        err_total++;
        wrap_up;
    end
endmodule
